// ---- dv/snvr_host_model.sv ----
// Host model that drives the serial link of the command port.
`timescale 1ns/1ps
`default_nettype none
module snvr_host_model (
	output var  logic shift_clock_in,
	output var  logic serial_in_pin,
	output var  logic chip_enable,
	input  wire logic serial_out,
	input  wire logic serial_out_oe
);
	localparam realtime HALF = 62.5;
	logic [15:0] rd_word;
	logic        oe_all;

	// The link rests with chip enable low and the clock stopped.
	initial begin
		shift_clock_in = 1'b0;
		serial_in_pin = 1'b0;
		chip_enable = 1'b0;
		rd_word = 16'h0000;
		oe_all = 1'b1;
	end

	// Sends lead zeros, then nbits of the frame MSB first, sampling read data.
	// The clock only runs inside the frame; between frames it stands still.
	task automatic xfer(input logic [23:0] bits, input int nbits,
		input int lead);
		int k;
		int j;
		#3;
		oe_all = 1'b1;
		chip_enable <= 1'b1;
		#(2*HALF);
		for (k = 0; k < lead + nbits; k++) begin
			j = k - lead;
			serial_in_pin <= (j < 0) ? 1'b0 : bits[23-j];
			#HALF;
			if (j >= 8) begin
				// A released output reads back inverted, so a dropped
				// drive enable shows up as a wrong word.
				rd_word[23-j] = serial_out_oe ? serial_out : ~serial_out;
				oe_all = oe_all & serial_out_oe;
			end
			shift_clock_in <= 1'b1;
			#HALF;
			shift_clock_in <= 1'b0;
		end
		#(2*HALF);
		chip_enable <= 1'b0;
		serial_in_pin <= ~serial_in_pin;
		#(4*HALF);
	endtask
endmodule
`default_nettype wire

// ---- dv/snvr_top_bench.sv ----
// Self-checking bench for the serial nonvolatile RAM command port.
`timescale 1ns/1ps
`default_nettype none
`include "snvr_map.svh"
module snvr_top_bench;
	localparam int STORE_N = 50;
	localparam int LIMIT   = 40000;
	logic        mclk;
	logic        rst_n;
	logic        store_n_pin;
	logic        recall_n_pin;
	wire logic   sck;
	wire logic   sdi;
	wire logic   ce;
	wire logic   sdo;
	wire logic   sdo_oe;
	wire logic   busy;
	logic [15:0] busy_cycles = 16'h0000;
	int          cycles = 0;
	int          num_errors = 0;
	int          check_count = 0;

	//--------------------------------------------------------------
	// Design, host and clocks
	//--------------------------------------------------------------
	snvr_top #(.STORE_CYCLES(STORE_N)) dut (
		.mclk(mclk), .rst_n(rst_n), .shift_clock_in(sck),
		.serial_in_pin(sdi), .chip_enable(ce), .store_n_pin(store_n_pin),
		.recall_n_pin(recall_n_pin), .serial_out(sdo),
		.serial_out_oe(sdo_oe), .store_busy(busy));
	snvr_host_model host (
		.shift_clock_in(sck), .serial_in_pin(sdi), .chip_enable(ce),
		.serial_out(sdo), .serial_out_oe(sdo_oe));

	// System clock at 100 MHz.
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	// Busy time is counted here so a store's length can be judged later.
	always @(posedge mclk) begin
		cycles <= cycles + 1;
		if (busy === 1'b1)
			busy_cycles <= busy_cycles + 16'h0001;
		if (cycles == LIMIT) begin
			num_errors++;
			wrap_up();
		end
	end

	//--------------------------------------------------------------
	// Shared tasks
	//--------------------------------------------------------------
	task automatic check(input string name, input logic [15:0] seen,
		input logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic cmd(input logic [2:0] op);
		host.xfer({1'b1, 4'h0, op, 16'h0000}, 8, 0);
	endtask

	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		host.xfer({1'b1, a, 3'h3, d}, 24, 0);
	endtask

	// The eighth bit is driven by the caller, since the device ignores it.
	task automatic rd_chk(input logic [3:0] a, input logic b8,
		input logic [15:0] exp);
		host.xfer({1'b1, a, 2'b11, b8, 16'h5555}, 24, 0);
		check("read word", host.rd_word, exp);
		check("drive in read", {15'h0, host.oe_all}, 16'h0001);
		check("drive after", {15'h0, sdo_oe}, 16'h0000);
	endtask

	task automatic pin_pulse(input logic is_store);
		@(posedge mclk);
		if (is_store) begin
			store_n_pin <= 1'b0;
		end else begin
			recall_n_pin <= 1'b0;
		end
		repeat (5) @(posedge mclk);
		store_n_pin <= 1'b1;
		recall_n_pin <= 1'b1;
		repeat (5) @(posedge mclk);
	endtask

	task automatic store_wait(input logic [15:0] base);
		int n;
		n = 0;
		while (busy !== 1'b0 && n < 400) begin
			@(posedge mclk);
			n++;
		end
		check("store length", busy_cycles - base, 16'(STORE_N));
	endtask

	//--------------------------------------------------------------
	// Scenarios
	//--------------------------------------------------------------
	task automatic t_locked();
		logic [15:0] b;
		wr(4'h0, 16'h1234);
		rd_chk(4'h0, 1'b0, 16'h0000);
		cmd(`SNVR_OP_SET);
		b = busy_cycles;
		cmd(`SNVR_OP_STO);
		repeat (20) @(posedge mclk);
		check("store no recall", busy_cycles - b, 16'h0000);
	endtask

	task automatic t_write();
		wr(4'hF, 16'hA5C3);
		wr(4'h0, 16'h5A3C);
		rd_chk(4'hF, 1'b0, 16'hA5C3);
		rd_chk(4'h0, 1'b1, 16'h5A3C);
		rd_chk(4'h7, 1'b0, 16'h0000);
	endtask

	// A cut instruction must leave nothing behind in the shifter.
	task automatic t_abort();
		host.xfer({1'b1, 4'h1, 3'h3, 16'hFFFF}, 5, 0);
		host.xfer({1'b1, 4'h2, 3'h3, 16'h0F0F}, 24, 3);
		rd_chk(4'h1, 1'b0, 16'h0000);
		rd_chk(4'h2, 1'b0, 16'h0F0F);
		cmd(`SNVR_OP_CLR);
		wr(4'hF, 16'hFFFF);
		rd_chk(4'hF, 1'b0, 16'hA5C3);
	endtask

	task automatic t_store();
		logic [15:0] b;
		cmd(`SNVR_OP_RCL);
		rd_chk(4'hF, 1'b0, 16'h0000);
		cmd(`SNVR_OP_SET);
		wr(4'h3, 16'hBEEF);
		b = busy_cycles;
		cmd(`SNVR_OP_STO);
		store_wait(b);
		wr(4'h3, 16'h1111);
		rd_chk(4'h3, 1'b0, 16'hBEEF);
		cmd(`SNVR_OP_SET);
		wr(4'h3, 16'h2222);
		pin_pulse(1'b0);
		rd_chk(4'h3, 1'b0, 16'hBEEF);
		cmd(`SNVR_OP_SET);
		wr(4'h3, 16'h7777);
		b = busy_cycles;
		pin_pulse(1'b1);
		store_wait(b);
		cmd(`SNVR_OP_SET);
		wr(4'h3, 16'h0000);
		cmd(`SNVR_OP_RCL);
		rd_chk(4'h3, 1'b0, 16'h7777);
	endtask

	task automatic wrap_up();
		$display("checks %0d errors %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// Reset for six cycles, then run every scenario in turn.
	initial begin
		rst_n = 1'b0;
		store_n_pin = 1'b1;
		recall_n_pin = 1'b1;
		repeat (6) @(posedge mclk);
		rst_n <= 1'b1;
		repeat (2) @(posedge mclk);
		t_locked();
		t_write();
		t_abort();
		t_store();
		wrap_up();
	end
endmodule
`default_nettype wire

// ---- logic/snvr_fifo.sv ----
// Parameterised valid/ready FIFO holding pending RAM write requests.
`timescale 1ns/1ps
`default_nettype none
module snvr_fifo #(
	parameter int WIDTH = 20,
	parameter int DEPTH = 8
) (
	input  wire logic mclk,
	input  wire logic rst_n,
	snvr_fifo_if.snk  push,
	snvr_fifo_if.src  pop
);
	localparam int PW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW-1:0]    wr_ptr_reg;
	logic [PW-1:0]    rd_ptr_reg;
	logic [PW:0]      count_reg;
	wire              do_push;
	wire              do_pop;

	// Full and empty come straight from the occupancy count.
	assign push.ready = (count_reg != (PW+1)'(DEPTH));
	assign pop.valid  = (count_reg != '0);
	assign pop.data   = mem[rd_ptr_reg];
	assign do_push    = push.valid && push.ready;
	assign do_pop     = pop.valid && pop.ready;

	// Storage itself needs no reset; only the pointers and the count do.
	always_ff @(posedge mclk) begin
		if (do_push) begin
			mem[wr_ptr_reg] <= push.data;
		end
	end

	// Pointers wrap at the power-of-two depth.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg  <= '0;
		end else begin
			wr_ptr_reg <= wr_ptr_reg + PW'(do_push);
			rd_ptr_reg <= rd_ptr_reg + PW'(do_pop);
			count_reg  <= count_reg + (PW+1)'(do_push) - (PW+1)'(do_pop);
		end
	end
endmodule
`default_nettype wire

// ---- logic/snvr_top.sv ----
// Serial instruction port of a 16x16 RAM shadowed by a nonvolatile array.
//
// Functional notes
// R1: Frame is start one, address nibble, opcode.
// R2: Opcode 000 clears, 100 sets write latch.
// R3: 001 stores RAM, 101 recalls nonvolatile array.
// R4: 011 writes addressed word; 11x reads it.
// R5: Serial input sampled on shift clock rising edges.
// R6: Output released except while shifting read data.
// R7: Host holds chip enable through whole transfer.
// R8: Write takes sixteen bits into addressed word.
// R9: First read bit after eighth falling edge.
// R10: Eighth bit of a read is ignored.
// R11: Early chip enable drop aborts, clears shifter.
// R12: Host gives exactly sixteen data clocks.
// R13: Stopped shift clock resumes at same bit.
// R14: Write latch cleared at power-up.
// R15: Writes and stores rejected without write latch.
// R16: Latch holds until disable, store, power-off.
// R17: Reads work regardless of write latch.
// R18: Hardware pins also start store and recall.
// R19: RAM holds sixteen sixteen-bit words.
// R20: Recalled data readable within 1.5 microseconds.
// R21: Store needs recall latch, write latch, request.
// R22: Store inhibits all else, then clears latch.
// R23: Any recall sets the previous-recall latch.
// R24: Recall pin low reloads RAM from array.
// R25: Zeros before the start bit are ignored.
`timescale 1ns/1ps
`default_nettype none
`include "snvr_map.svh"
module snvr_top #(
	parameter int unsigned STORE_CYCLES =
		`SNVR_STORE_MS * 1000 * `SNVR_MCLK_MHZ
) (
	input  wire logic mclk,
	input  wire logic rst_n,
	input  wire logic shift_clock_in,
	input  wire logic serial_in_pin,
	input  wire logic chip_enable,
	input  wire logic store_n_pin,
	input  wire logic recall_n_pin,
	output var  logic serial_out,
	output var  logic serial_out_oe,
	output var  logic store_busy
);
	import snvr_pkg::*;

	localparam int RCL_CYC = `SNVR_RECALL_NS * `SNVR_MCLK_MHZ / 1000;
	localparam int RCL_MAX = (RCL_CYC < 1) ? 1 : RCL_CYC;

	// ------------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------------
	logic [`SNVR_PIN_COUNT-1:0] pin_raw;
	logic [`SNVR_PIN_COUNT-1:0] meta_reg;
	logic [`SNVR_PIN_COUNT-1:0] sync_reg;
	logic [`SNVR_PIN_COUNT-1:0] last_reg;

	assign pin_raw = {store_n_pin, recall_n_pin, chip_enable,
		serial_in_pin, shift_clock_in};

	// Every pin is asynchronous, so each passes two flops before use.
	for (genvar i = 0; i < `SNVR_PIN_COUNT; i++) begin : g_sync
		always_ff @(posedge mclk or negedge rst_n) begin
			if (!rst_n) begin
				meta_reg[i] <= 1'b0;
				sync_reg[i] <= 1'b0;
				last_reg[i] <= 1'b0;
			end else begin
				meta_reg[i] <= pin_raw[i];
				sync_reg[i] <= meta_reg[i];
				last_reg[i] <= sync_reg[i];
			end
		end
	end

	// ------------------------------------------------------------------
	// Decode
	// ------------------------------------------------------------------
	snvr_state_t state_reg;
	snvr_state_t state_next;
	logic [4:0]  cnt_reg;
	logic [15:0] shin_reg;
	snvr_addr_t  addr_reg;
	snvr_word_t  shout_reg;
	logic        wel_reg;
	logic        prev_reg;
	logic        storing_reg;
	logic [31:0] store_cnt_reg;
	logic        pend_valid_reg;
	snvr_wreq_t  pend_reg;
	snvr_word_t  ram [`SNVR_WORDS];
	snvr_word_t  nvm [`SNVR_WORDS];

	// Edges are found on the synchronised copies, never the first flop.
	wire        sck_rise = sync_reg[0] && !last_reg[0];  // [R5]
	wire        sck_fall = !sync_reg[0] && last_reg[0];
	wire        din      = sync_reg[1];
	wire        ce       = sync_reg[2];
	wire        hw_rcl   = !sync_reg[3] && last_reg[3];  // [R18] [R24]
	wire        hw_sto   = !sync_reg[4] && last_reg[4];  // [R18]
	wire        abort    = !ce || storing_reg;            // [R11] [R22]
	wire        bit_rise = sck_rise && !abort;
	wire        instr_end = bit_rise && state_reg == SNVR_INSTR
		&& cnt_reg == `SNVR_INSTR_LAST;                   // [R1]
	wire [2:0]  opcode   = {shin_reg[1:0], din};
	wire        is_read  = instr_end && shin_reg[1] && shin_reg[0]; // [R10]
	wire        is_write = instr_end && opcode == `SNVR_OP_WR;       // [R4]
	wire        cmd_clr  = instr_end && opcode == `SNVR_OP_CLR;      // [R2]
	wire        cmd_set  = instr_end && opcode == `SNVR_OP_SET;      // [R2]
	wire        cmd_sto  = instr_end && opcode == `SNVR_OP_STO;      // [R3]
	wire        cmd_rcl  = instr_end && opcode == `SNVR_OP_RCL;      // [R3]
	wire        store_go = (cmd_sto || hw_sto) && wel_reg && prev_reg
		&& !storing_reg;                                  // [R21] [R15]
	wire        store_end = storing_reg
		&& store_cnt_reg == STORE_CYCLES - 1;
	wire        recall_go = (cmd_rcl || hw_rcl) && !storing_reg
		&& !store_go;                                     // [R24]
	wire        data_end = bit_rise && cnt_reg == `SNVR_DATA_LAST;
	wire        word_done = data_end && state_reg == SNVR_WDATA;
	snvr_wreq_t new_req;
	assign new_req.addr = addr_reg;
	assign new_req.data = {shin_reg[14:0], din};             // [R8]

	// ------------------------------------------------------------------
	// Frame sequencer
	// ------------------------------------------------------------------
	// A stalled shift clock just leaves the state where it is.
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			SNVR_IDLE: if (bit_rise && din) state_next = SNVR_INSTR; // [R25]
			SNVR_INSTR: begin
				if (is_read) state_next = SNVR_RSETUP;
				else if (is_write) state_next = SNVR_WDATA;
				else if (instr_end) state_next = SNVR_DONE;
			end
			SNVR_RSETUP: if (sck_fall) state_next = SNVR_RDATA;  // [R9]
			SNVR_RDATA: if (data_end) state_next = SNVR_DONE;
			SNVR_WDATA: if (data_end) state_next = SNVR_DONE;
			SNVR_DONE: state_next = SNVR_DONE;
		endcase
		if (abort) state_next = SNVR_IDLE;                   // [R11]
	end

	// State, bit counter and input shifter; cleared when deselected.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= SNVR_IDLE;
			cnt_reg   <= '0;
			shin_reg  <= '0;
			addr_reg  <= '0;
		end else begin
			state_reg <= state_next;
			if (abort || instr_end || state_reg == SNVR_IDLE) begin
				cnt_reg <= '0;                               // [R11]
			end else if (bit_rise) begin
				cnt_reg <= cnt_reg + 5'h01;                  // [R13]
			end
			if (abort || state_reg == SNVR_IDLE) begin
				shin_reg <= '0;
			end else if (bit_rise) begin
				shin_reg <= {shin_reg[14:0], din};           // [R5]
			end
			if (instr_end) addr_reg <= shin_reg[5:2];        // [R4]
		end
	end

	// Read data leaves MSB first; the pin is released after bit 16.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			shout_reg     <= '0;
			serial_out    <= 1'b0;
			serial_out_oe <= 1'b0;
		end else if (abort || state_next != SNVR_RDATA) begin
			serial_out_oe <= 1'b0;                           // [R6]
		end else if (state_reg == SNVR_RSETUP) begin
			shout_reg     <= ram[addr_reg];                  // [R17]
			serial_out    <= ram[addr_reg][`SNVR_WORD_MSB];  // [R9]
			serial_out_oe <= 1'b1;
		end else if (bit_rise) begin
			shout_reg  <= {shout_reg[14:0], 1'b0};
			serial_out <= shout_reg[`SNVR_WORD_MSB-1];       // [R9]
		end
	end

	// ------------------------------------------------------------------
	// Latches and store timer
	// ------------------------------------------------------------------
	// A finished store wins over a same-cycle enable command.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			wel_reg       <= 1'b0;                           // [R14]
			prev_reg      <= 1'b0;
			storing_reg   <= 1'b0;
			store_cnt_reg <= '0;
		end else begin
			if (store_end || cmd_clr) wel_reg <= 1'b0;       // [R16] [R22]
			else if (cmd_set) wel_reg <= 1'b1;               // [R2]
			if (recall_go) prev_reg <= 1'b1;                 // [R23]
			if (store_go) storing_reg <= 1'b1;
			else if (store_end) storing_reg <= 1'b0;
			store_cnt_reg <= storing_reg ? store_cnt_reg + 32'h1 : '0;
		end
	end
	assign store_busy = storing_reg;

	// ------------------------------------------------------------------
	// Write queue and arrays
	// ------------------------------------------------------------------
	snvr_fifo_if #(.WIDTH($bits(snvr_wreq_t))) wq_in ();
	snvr_fifo_if #(.WIDTH($bits(snvr_wreq_t))) wq_out ();
	snvr_wreq_t drain_req;

	// A queue word may be dropped if a new one arrives while full.
	assign wq_in.valid  = pend_valid_reg;
	assign wq_in.data   = pend_reg;
	assign wq_out.ready = !storing_reg && !recall_go;        // [R22]
	assign drain_req    = wq_out.data;

	snvr_fifo #(
		.WIDTH ($bits(snvr_wreq_t)),
		.DEPTH (`SNVR_FIFO_DEPTH)
	) u_wq (
		.mclk  (mclk),
		.rst_n (rst_n),
		.push  (wq_in),
		.pop   (wq_out)
	);

	// Only enabled writes are queued; a new word beats a same-cycle push.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			pend_valid_reg <= 1'b0;
			pend_reg       <= '0;
		end else if (word_done && wel_reg) begin             // [R15]
			pend_valid_reg <= 1'b1;
			pend_reg       <= new_req;                       // [R8]
		end else if (wq_in.ready) begin
			pend_valid_reg <= 1'b0;
		end
	end

	// Recall copies the whole array in one cycle, well inside the limit.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			for (int w = 0; w < `SNVR_WORDS; w++) begin
				ram[w] <= '0;                                // [R19]
				nvm[w] <= '0;
			end
		end else if (recall_go) begin
			for (int w = 0; w < `SNVR_WORDS; w++) begin
				ram[w] <= nvm[w];                            // [R3] [R20]
			end
		end else if (store_end) begin
			for (int w = 0; w < `SNVR_WORDS; w++) begin
				nvm[w] <= ram[w];                            // [R3]
			end
		end else if (wq_out.valid && wq_out.ready) begin
			ram[drain_req.addr] <= drain_req.data;           // [R4]
		end
	end

	// ------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);

	oe_read_only_a: assert property ( // [R6]
		serial_out_oe |-> state_reg == SNVR_RDATA && ce)
		else $error("Output enabled outside read data.");
	first_bit_a: assert property ( // [R9]
		state_reg == SNVR_RSETUP && sck_fall && !abort |=>
		serial_out_oe && serial_out == $past(ram[addr_reg][15]))
		else $error("First read bit wrong after falling edge.");
	abort_clear_a: assert property ( // [R11]
		!ce |=> state_reg == SNVR_IDLE && shin_reg == '0 && cnt_reg == '0)
		else $error("Deselect did not clear the frame.");
	clr_latch_a: assert property ( // [R2]
		cmd_clr |=> !wel_reg)
		else $error("Disable command left write latch set.");
	store_gate_a: assert property ( // [R21]
		$rose(storing_reg) |-> $past(wel_reg && prev_reg))
		else $error("Store started without both latches.");
	store_end_a: assert property ( // [R22]
		$fell(storing_reg) |-> !wel_reg && nvm[0] == $past(ram[0]))
		else $error("Store end did not copy or clear latch.");
	store_inhibit_a: assert property ( // [R22]
		storing_reg |=> state_reg == SNVR_IDLE && !serial_out_oe)
		else $error("Frame activity during store.");
	recall_latch_a: assert property ( // [R23]
		recall_go |=> prev_reg ##0 ram[1] == $past(nvm[1]))
		else $error("Recall did not load RAM or set latch.");
	stall_hold_a: assert property ( // [R13]
		!sck_rise && !abort && state_reg != SNVR_IDLE |=>
		$stable(cnt_reg) && $stable(shin_reg))
		else $error("Shifter moved without a clock edge.");
	reject_write_a: assert property ( // [R15]
		word_done && !wel_reg && !pend_valid_reg |=> !pend_valid_reg)
		else $error("Write queued with latch clear.");
	read_len_a: assert property ( // [R9]
		$rose(serial_out_oe) ##1 (serial_out_oe && !sck_rise)[*4] |=>
		serial_out_oe)
		else $error("Read output dropped while clock stalled.");
	recall_time_a: assert property ( // [R20]
		recall_go |-> ##[1:RCL_MAX] ram[2] == nvm[2])
		else $error("Recall data not in RAM in time.");

	read_frame_c: cover property (is_read ##[1:300] $fell(serial_out_oe));
	write_push_c: cover property (word_done && wel_reg);
	store_done_c: cover property ($fell(storing_reg));
	hw_recall_c: cover property (hw_rcl && recall_go);
endmodule
`default_nettype wire

// ---- shared/snvr_fifo_if.sv ----
// Valid/ready channel between the frame logic and the write FIFO.
`timescale 1ns/1ps
`default_nettype none
interface snvr_fifo_if #(parameter int WIDTH = 20);
	logic             valid;
	logic             ready;
	logic [WIDTH-1:0] data;
	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// ---- shared/snvr_map.svh ----
// Constants of the serial nonvolatile RAM command port.
`ifndef SNVR_MAP_SVH
`define SNVR_MAP_SVH
`define SNVR_OP_CLR      3'h0
`define SNVR_OP_STO      3'h1
`define SNVR_OP_WR       3'h3
`define SNVR_OP_SET      3'h4
`define SNVR_OP_RCL      3'h5
`define SNVR_INSTR_LAST  5'h06
`define SNVR_DATA_LAST   5'h0F
`define SNVR_WORD_MSB    15
`define SNVR_WORDS       16
`define SNVR_FIFO_DEPTH  8
`define SNVR_MCLK_MHZ    100
`define SNVR_STORE_MS    10
`define SNVR_RECALL_NS   1500
`define SNVR_PIN_COUNT   5
`endif

// ---- shared/snvr_pkg.sv ----
// Types shared by the serial nonvolatile RAM command port.
`default_nettype none
package snvr_pkg;
	typedef logic [15:0] snvr_word_t;
	typedef logic [3:0]  snvr_addr_t;
	typedef struct packed {
		snvr_addr_t addr;
		snvr_word_t data;
	} snvr_wreq_t;
	typedef enum logic [2:0] {
		SNVR_IDLE, SNVR_INSTR, SNVR_RSETUP, SNVR_RDATA, SNVR_WDATA, SNVR_DONE
	} snvr_state_t;
endpackage
`default_nettype wire
